// [gpe_consts.svh]
// Notes on behaviour
// - power button override clears all event0 enables
// - resume reset clears event0 low byte
// - of the resets, only rtc reset clears event0 high byte
// - pme enable gates pme wake and sci
// - pme wakes s1-s4, s5 only via sleep-enable
// - battery-low fall with its enable raises smi/sci; low blocks wake
// - ring enable survives resume reset, cf9 write
// - ring enable gates ring flag wake
// - watchdog enable gates watchdog sci
// - codec enable gates codec wake
// - usb b enable gates usb b wake
// - usb a enable gates usb a wake
// - polarity bit picks thermal active level
// - thermal enable sets flag, raises pm event
// - input low (or inverted high) sets gpi flag
// - write-one clears flag unless input active
// - enabled gpi flag in sleep wakes system
// - enabled gpi flag in s0 raises routed smi/sci
// - gpi positions 5 and 2 not implemented
// - resume reset clears event1 enables
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH
`define GPE_EV0_EN_OFS 8'h2a
`define GPE_EV1_STS_OFS 8'h2c
`define GPE_EV1_EN_OFS 8'h2e
`define GPE_EV0_RST 16'h0000
`define GPE_EV1_RST 16'h0000
`define GPE_EV0_MASK 16'h0d7d
`define GPE_EV1_MASK 16'hffdb
`define GPE_BIT_THERMAL_REPORT_ENABLE 0
`define GPE_BIT_THERMAL_POLARITY 2
`define GPE_BIT_USB_A 3
`define GPE_BIT_USB_B 4
`define GPE_BIT_CODEC 5
`define GPE_BIT_WDOG 6
`define GPE_BIT_RING 8
`define GPE_BIT_BATTERY_LOW_N 10
`define GPE_BIT_PME 11
`endif

// [gpe_pkg.sv]
package gpe_pkg;
    typedef enum logic [2:0] {
        GPE_S0, GPE_S1, GPE_S3, GPE_S4, GPE_S5
    } gpe_state_e;
    typedef struct packed {
        logic pme;
        logic ring;
        logic wdog_sci;
        logic codec;
        logic usb_a;
        logic usb_b;
    } gpe_flags_s;
    typedef struct packed {
        logic wake;
        logic sci;
        logic smi;
    } gpe_req_s;
endpackage : gpe_pkg

// [gpe_wake_enable_reg.sv]
`include "gpe_consts.svh"
module gpe_wake_enable_reg (
    input wire logic sys_clk, // system clock
    input wire logic resume_well_reset_n, // resume well reset
    input wire logic rtc_well_reset_n, // rtc well reset
    input wire logic pwr_btn_override, // clears all bits
    input wire logic wr_en, // event0 write strobe
    input wire logic [15:0] wr_data, // write data
    output logic [15:0] enable // register value
);
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic [15:0] wmask;

    always_comb begin
        wmask = wr_data & `GPE_EV0_MASK;
        next_low = low_q;
        next_high = high_q;
        if (wr_en) begin
            next_low = wmask[7:0];
            next_high = wmask[15:8];
        end
        if (pwr_btn_override) begin
            next_low = 8'h00;
            next_high = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge resume_well_reset_n) begin
        if (!resume_well_reset_n) begin
            low_q <= 8'(`GPE_EV0_RST);
        end else begin
            low_q <= next_low;
        end
    end

    // high byte ignores resume reset and warm reset writes
    always_ff @(posedge sys_clk or negedge rtc_well_reset_n) begin
        if (!rtc_well_reset_n) begin
            high_q <= 8'(`GPE_EV0_RST >> 8);
        end else begin
            high_q <= next_high;
        end
    end

    assign enable = {high_q, low_q};
endmodule : gpe_wake_enable_reg

// [gpe_gpi_status.sv]
`include "gpe_consts.svh"
module gpe_gpi_status #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk, // system clock
    input wire logic resume_well_reset_n, // resume well reset
    input wire logic [WIDTH-1:0] gpio_level, // gpio pin levels
    input wire logic [WIDTH-1:0] gpio_is_input, // gpio direction
    input wire logic [WIDTH-1:0] gp_input_invert, // per pin invert
    input wire logic clr_en, // status write strobe
    input wire logic [WIDTH-1:0] clr_data, // write-one-clear data
    output logic [WIDTH-1:0] gp_input_flag // status bits
);
    localparam logic [15:0] IMPL = `GPE_EV1_MASK;
    logic [WIDTH-1:0] flag_q;
    logic [WIDTH-1:0] next_flag;
    logic [WIDTH-1:0] active;

    always_comb begin
        active = '0;
        next_flag = flag_q;
        for (int i = 0; i < WIDTH; i++) begin
            active[i] = IMPL[i] & gpio_is_input[i]
                & (gpio_level[i] == gp_input_invert[i]);
            // set wins; clear refused while input active
            if (clr_en && clr_data[i]) begin
                next_flag[i] = 1'b0;
            end
            if (active[i]) begin
                next_flag[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resume_well_reset_n) begin
        if (!resume_well_reset_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= next_flag;
        end
    end

    assign gp_input_flag = flag_q;
endmodule : gpe_gpi_status

// [gpe_event_gate.sv]
`include "gpe_consts.svh"
module gpe_event_gate (
    input wire logic sys_clk, // system clock
    input wire logic resume_well_reset_n, // resume well reset
    input wire logic rtc_well_reset_n, // rtc well reset
    input wire logic pwr_btn_override, // override pulse
    input wire logic [7:0] io_addr, // io offset from pm_io_base
    input wire logic io_wr, // io write strobe
    input wire logic io_rd, // io read strobe
    input wire logic [15:0] io_wdata, // io write data
    output logic [15:0] io_rdata, // io read data
    input wire gpe_pkg::gpe_flags_s ev0_flags, // event0 status flags
    input wire logic battery_low_n, // battery low, active low
    input wire logic sci_select, // 1 routes to sci
    input wire logic thermal_alert_pin, // thermal input
    input wire gpe_pkg::gpe_state_e sleep_state, // current state
    input wire logic s5_by_sleep_entry, // s5 via sleep_entry_enable
    input wire logic [15:0] gpio_level, // gpio levels
    input wire logic [15:0] gpio_is_input, // gpio direction
    input wire logic [15:0] gp_input_invert, // gpio invert
    input wire logic [15:0] gp_input_route, // 1 = sci, 0 = smi
    output logic thermal_flag, // thermal status level
    output gpe_pkg::gpe_req_s req // wake, sci, smi requests
);
    logic [15:0] ev0_en;
    logic [15:0] ev1_en;
    logic [15:0] next_ev1_en;
    logic [15:0] gpi_flag;
    logic [15:0] next_rdata;
    logic next_thermal;
    logic thermal_q;
    logic bat_q;
    logic next_bat;
    logic thermal_active;
    logic bat_fall;
    logic asleep;
    logic pme_ok_state;
    logic [15:0] gpi_hit;
    gpe_pkg::gpe_req_s next_req;

    gpe_wake_enable_reg u_ev0 (
        .sys_clk(sys_clk),
        .resume_well_reset_n(resume_well_reset_n),
        .rtc_well_reset_n(rtc_well_reset_n),
        .pwr_btn_override(pwr_btn_override),
        .wr_en(io_wr && io_addr == `GPE_EV0_EN_OFS),
        .wr_data(io_wdata),
        .enable(ev0_en)
    );

    gpe_gpi_status #(.WIDTH(16)) u_gpi (
        .sys_clk(sys_clk),
        .resume_well_reset_n(resume_well_reset_n),
        .gpio_level(gpio_level),
        .gpio_is_input(gpio_is_input),
        .gp_input_invert(gp_input_invert),
        .clr_en(io_wr && io_addr == `GPE_EV1_STS_OFS),
        .clr_data(io_wdata),
        .gp_input_flag(gpi_flag)
    );

    always_comb begin
        next_ev1_en = ev1_en;
        if (io_wr && io_addr == `GPE_EV1_EN_OFS) begin
            next_ev1_en = io_wdata & `GPE_EV1_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge resume_well_reset_n) begin
        if (!resume_well_reset_n) begin
            ev1_en <= `GPE_EV1_RST;
        end else begin
            ev1_en <= next_ev1_en;
        end
    end

    // thermal flag and battery-low edge state
    always_comb begin
        thermal_active = (thermal_alert_pin ==
            ev0_en[`GPE_BIT_THERMAL_POLARITY]);
        next_thermal = thermal_q;
        if (io_wr && io_addr == `GPE_EV1_STS_OFS
            && io_wdata[0]) begin
            next_thermal = 1'b0;
        end
        if (thermal_active && ev0_en[`GPE_BIT_THERMAL_REPORT_ENABLE]) begin
            next_thermal = 1'b1;
        end
        next_bat = battery_low_n;
        bat_fall = bat_q && !battery_low_n;
    end

    always_ff @(posedge sys_clk or negedge resume_well_reset_n) begin
        if (!resume_well_reset_n) begin
            thermal_q <= 1'b0;
            bat_q <= 1'b1;
        end else begin
            thermal_q <= next_thermal;
            bat_q <= next_bat;
        end
    end

    // request generation
    always_comb begin
        asleep = (sleep_state != gpe_pkg::GPE_S0);
        pme_ok_state = asleep && (sleep_state != gpe_pkg::GPE_S5
            || s5_by_sleep_entry);
        gpi_hit = gpi_flag & ev1_en;
        next_req = '0;
        // wake sources; low battery vetoes all wakes
        next_req.wake = ((ev0_flags.pme && ev0_en[`GPE_BIT_PME]
                && pme_ok_state)
            || (ev0_flags.ring && ev0_en[`GPE_BIT_RING])
            || (ev0_flags.codec && ev0_en[`GPE_BIT_CODEC])
            || (ev0_flags.usb_b && ev0_en[`GPE_BIT_USB_B])
            || (ev0_flags.usb_a && ev0_en[`GPE_BIT_USB_A])
            || (asleep && |gpi_hit))
            && battery_low_n;
        next_req.sci = (ev0_flags.pme && ev0_en[`GPE_BIT_PME]
                && !asleep)
            || (ev0_flags.wdog_sci && ev0_en[`GPE_BIT_WDOG])
            || (thermal_q && sci_select)
            || (bat_fall && ev0_en[`GPE_BIT_BATTERY_LOW_N]
                && sci_select)
            || (!asleep && |(gpi_hit & gp_input_route));
        next_req.smi = (thermal_q && !sci_select)
            || (bat_fall && ev0_en[`GPE_BIT_BATTERY_LOW_N]
                && !sci_select)
            || (!asleep && |(gpi_hit & ~gp_input_route));
        next_rdata = 16'h0000;
        if (io_rd) begin
            case (io_addr)
                `GPE_EV0_EN_OFS: next_rdata = ev0_en;
                `GPE_EV1_STS_OFS: next_rdata = gpi_flag;
                `GPE_EV1_EN_OFS: next_rdata = ev1_en;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resume_well_reset_n) begin
        if (!resume_well_reset_n) begin
            req <= '0;
            io_rdata <= 16'h0000;
        end else begin
            req <= next_req;
            io_rdata <= next_rdata;
        end
    end

    assign thermal_flag = thermal_q;
endmodule : gpe_event_gate

// [gpe_sva.sv]
module gpe_sva (
    input wire logic sys_clk, // clk
    input wire logic resume_well_reset_n, // rst
    input wire logic rtc_well_reset_n, // rst
    input wire logic pwr_btn_override, // ovr
    input wire logic [7:0] io_addr, // ofs
    input wire logic io_wr, // wr
    input wire logic io_rd, // rd
    input wire logic [15:0] io_wdata, // wd
    input wire logic [15:0] io_rdata, // rd
    input wire logic battery_low_n, // bat
    input wire gpe_pkg::gpe_req_s req // req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resume_well_reset_n);
    a_unmapped_zero: assert property (
        io_rd && !(io_addr inside {8'h2a, 8'h2c, 8'h2e}) |=>
        io_rdata == 16'h0000) else $error("unmapped read");
    a_ev0_reserved: assert property (
        io_rd && io_addr == 8'h2a |=> (io_rdata & 16'hf282) == 16'h0000)
        else $error("reserved bit set");
    a_ev1_gaps: assert property (
        io_rd && io_addr inside {8'h2c, 8'h2e} |=>
        !io_rdata[5] && !io_rdata[2]) else $error("gap bit set");
    a_override_clear: assert property (
        pwr_btn_override && !io_wr ##1 io_rd && io_addr == 8'h2a && !io_wr
        |=> io_rdata == 16'h0000) else $error("override kept bits");
    a_battery_low_n_blocks: assert property (
        !battery_low_n [*2] |-> !req.wake) else $error("wake in low");
    a_rtc_high_clear: assert property (
        !rtc_well_reset_n ##1 io_rd && io_addr == 8'h2a && !io_wr |=>
        io_rdata[15:8] == 8'h00) else $error("rtc reset kept");
    a_resume_low: assert property (
        $rose(resume_well_reset_n) && io_rd && io_addr == 8'h2a |=>
        io_rdata[7:0] == 8'h00) else $error("resume reset kept");
    a_ev0_readback: assert property (
        io_wr && io_addr == 8'h2a && rtc_well_reset_n && !pwr_btn_override
        ##1 !io_wr && rtc_well_reset_n && !pwr_btn_override
        ##1 io_rd && io_addr == 8'h2a && !io_wr && rtc_well_reset_n &&
        !pwr_btn_override |=> io_rdata == ($past(io_wdata, 3) & 16'h0d7d))
        else $error("readback wrong");
endmodule : gpe_sva
bind gpe_event_gate gpe_sva u_sva (.*);

// [gpe_src_model.sv]
module gpe_src_model (
    input wire logic sys_clk, // clk
    input wire logic [15:0] active, // sources asserting
    output logic [15:0] gpio_level // pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // sources pull their pin low to assert
    always_ff @(posedge sys_clk) begin
        gpio_level <= ~active;
    end
endmodule : gpe_src_model

// [tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, resume_well_reset_n = 0, rtc_well_reset_n = 0;
    logic pwr_btn_override = 0, io_wr = 0, io_rd = 0, rd_pend = 0;
    logic battery_low_n = 1, sci_select = 1, thermal_alert_pin = 0;
    logic s5_by_sleep_entry = 0, thermal_flag;
    logic [7:0] io_addr = 8'h00;
    logic [15:0] io_wdata = 0, io_rdata, gpio_level, gpio_active = 0;
    logic [15:0] gpio_is_input = 16'hffff, gp_input_invert = 0;
    logic [15:0] gp_input_route = 0, rnd;
    gpe_pkg::gpe_flags_s ev0_flags = 6'h00;
    gpe_pkg::gpe_state_e sleep_state = gpe_pkg::GPE_S0;
    gpe_pkg::gpe_req_s req;
    logic [15:0] exp_q[$];
    int err_total = 0, total_checks = 0;
    int en_bit[6] = '{3, 4, 5, 8, 11, 6};
    logic [5:0] flag_of[6] = '{6'h02, 6'h01, 6'h04, 6'h10, 6'h20, 6'h08};
    always #5 sys_clk = ~sys_clk;
    gpe_src_model pins (.sys_clk(sys_clk), .active(gpio_active),
        .gpio_level(gpio_level));
    gpe_event_gate dut (.*);
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [15:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        @(negedge sys_clk);
        io_wr = 0;
        // idle cycle, so a next call never re-raises the strobe at once
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [15:0] e);
        io_addr = a;
        io_rd = 1;
        exp_q.push_back(e);
        @(negedge sys_clk);
        io_rd = 0;
        @(negedge sys_clk);
    endtask : rd
    // steady levels only, so a spare cycle costs nothing
    task automatic req_is(int b, logic e);
        repeat (3) @(negedge sys_clk);
        chk("req", {15'h0, e}, {15'h0, req[b]});
    endtask : req_is
    task automatic results;
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    always @(posedge sys_clk) rd_pend <= io_rd;
    always @(negedge sys_clk) begin
        if (rd_pend) chk("io_rdata", exp_q.pop_front(), io_rdata);
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        rnd = 16'($urandom(7)) & 16'hfffe;
        repeat (16) @(negedge sys_clk);
        resume_well_reset_n = 1;
        rtc_well_reset_n = 1;
        for (int a = 8'h2a; a < 8'h32; a += 2) rd(8'(a), 16'h0000);
        wr(8'h2a, rnd);
        rd(8'h2a, rnd & 16'h0d7d);
        for (int i = 0; i < 6; i++) begin
            ev0_flags = flag_of[i];
            sleep_state = (i == 5) ? gpe_pkg::GPE_S0 : gpe_pkg::GPE_S3;
            for (int e = 0; e < 2; e++) begin
                wr(8'h2a, 16'(e) << en_bit[i]);
                req_is((i == 5) ? 1 : 2, e[0]);
            end
        end
        ev0_flags = 6'h20;
        wr(8'h2a, 16'h0800);
        sleep_state = gpe_pkg::GPE_S5;
        s5_by_sleep_entry = 1;
        req_is(2, 1'b1);
        battery_low_n = 0;
        req_is(2, 1'b0);
        battery_low_n = 1;
        s5_by_sleep_entry = 0;
        req_is(2, 1'b0);
        wr(8'h2a, 16'hffff);
        resume_well_reset_n = 0;
        @(negedge sys_clk);
        resume_well_reset_n = 1;
        rd(8'h2a, 16'h0d00);
        rtc_well_reset_n = 0;
        @(negedge sys_clk);
        rtc_well_reset_n = 1;
        rd(8'h2a, 16'h0000);
        wr(8'h2a, 16'hffff);
        pwr_btn_override = 1;
        @(negedge sys_clk);
        pwr_btn_override = 0;
        rd(8'h2a, 16'h0000);
        sleep_state = gpe_pkg::GPE_S0;
        ev0_flags = 6'h00;
        for (int p = 0; p < 2; p++) begin
            // p=0 routes thermal to smi, p=1 to sci
            sci_select = p[0];
            thermal_alert_pin = ~p[0];
            wr(8'h2a, 16'h0001 | (16'(p) << 2));
            req_is(p, 1'b0);
            chk("thermal_flag", 16'h0000, {15'h0, thermal_flag});
            thermal_alert_pin = p[0];
            req_is(p, 1'b1);
            chk("thermal_flag", 16'h0001, {15'h0, thermal_flag});
            thermal_alert_pin = ~p[0];
            wr(8'h2c, 16'h0001);
            // drop enables before the next polarity, else a stale set
            wr(8'h2a, 16'h0000);
        end
        wr(8'h2a, 16'h0400);
        battery_low_n = 0;
        @(negedge sys_clk);
        chk("req", 16'h0002, {13'h0, req});
        battery_low_n = 1;
        wr(8'h2e, 16'hffff);
        rd(8'h2e, 16'hffdb);
        gp_input_route = 16'h0008;
        gp_input_invert = 16'h0010;
        gpio_is_input = 16'hfffd;
        gpio_active = 16'h002e;
        req_is(1, 1'b1);
        rd(8'h2c, 16'h0018);
        wr(8'h2c, 16'hffff);
        rd(8'h2c, 16'h0018);
        gp_input_route = 16'h0000;
        req_is(0, 1'b1);
        sleep_state = gpe_pkg::GPE_S3;
        req_is(2, 1'b1);
        gpio_active = 16'h0000;
        gp_input_invert = 16'h0000;
        repeat (2) @(negedge sys_clk);
        wr(8'h2c, 16'hffff);
        rd(8'h2c, 16'h0000);
        @(negedge sys_clk);
        results();
    end
endmodule : tb
